// ---- src/ats_sequencer.sv ----
// coded safety sensor: pairing sequencer, indicators, parameter port, apb registers
//
// Chosen here: the placing of the registers and register access over APB.
`include "ats_consts.svh"
`timescale 1ns/1ps
`default_nettype none

//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - slave address 1 to 31 is accepted
// - yellow steady while paired actuator present; here yellow stays off in ST_INHIBIT even with the paired actuator present
// - hysteresis zone turns yellow flashing after delay
// - standard coding works without any pairing
// - unpaired actuator after power-up starts pairing, 1 Hz
// - after 10 s, 3 Hz flashes ask power-off
// - no power-off in 5 min: abort, five flashes
// - taught code stored once seen after power-up
// - one-time variant refuses pairing once stored
// - repeatable variant re-pairs, new code replaces old
// - repeatable pairing holds ten minute release inhibit
// - duo led flashes until inhibit over, detected
// - power loss restarts full inhibit interval
// - detection variant reports actuator number 1-15
// - detection variant reports zero without actuator
// - standard parameter bits and peripheral fault flag
module ats_sequencer import ats_pkg::*; #(
	parameter int TICK_CYCLES = `ATS_TICK_CYC
) (
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire ats_sense_t sense_in,
	input wire ats_nv_t nv_in,
	output logic nv_wr_out,
	output ats_nv_t nv_out,
	output logic release_out,
	output logic yel_led_out,
	output logic duo_red_out,
	output logic duo_grn_out,
	output logic [3:0] param_out,
	output logic fault_flag_out,
	output logic irq_out
);

	ats_state_t st;
	ats_state_t nx;
	ats_sense_t sn;
	logic [4:0] ev;
	logic [4:0] clr;
	logic matched;
	logic paired;
	logic hyst_long;
	logic blink_on;
	logic inhib_act;
	logic [6:0] period;

	//////////////////////////////////////////////////////////////////////////
	ats_pin_sync #(.W($bits(ats_sense_t))) u_sync (
		.ref_clk_in(ref_clk_in),
		.resetn_in(resetn_in),
		.pin_in(sense_in),
		.pin_out(sn)
	);

	//////////////////////////////////////////////////////////////////////////
	always_comb begin
		nx = st;
		ev = '0;
		clr = '0;
		nx.nv_wr = 1'b0;
		nx.pready = 1'b0;
		nx.pslverr = 1'b0;

		// prescaler and free blink counter
		nx.tick = (st.pre == 21'(TICK_CYCLES - 1));
		nx.pre = nx.tick ? '0 : st.pre + 21'h000001;
		if (st.tick) begin
			nx.blink = (st.blink == 7'(`ATS_BLINK_PER - 1)) ? '0 : st.blink + 7'h01;
		end
		blink_on = (st.blink < 7'(`ATS_BLINK_PER / 2));

		case (st.fsm)
			ST_TEACH: period = 7'(`ATS_TEACH_PER);
			ST_PWROFF: period = 7'(`ATS_REQ_PER);
			default: period = 7'(`ATS_BLINK_PER);
		endcase
		if (st.tick) begin
			nx.ph = (st.ph == period - 7'h01) ? '0 : st.ph + 7'h01;
		end

		matched = sn.present && st.nv.stored_valid && (sn.code == st.nv.stored_code);
		paired = sn.present && ((st.ctrl.variant == standard_variant) || matched);
		hyst_long = (st.fsm == ST_RUN) && (st.tmr >= 16'(`ATS_HYST_DLY_TICKS));
		inhib_act = (st.fsm == ST_INHIBIT) || st.need_detect;

		// apb slave, one wait state
		if (psel_in && penable_in && !st.pready) begin
			nx.pready = 1'b1;
			nx.prdata = '0;
			case (paddr_in)
				`ATS_OFF_CTRL: begin
					if (pwrite_in) begin
						if (pwdata_in[`ATS_CTRL_ADDR_LSB +: 5] >= `ATS_CTRL_ADDR_MIN) begin
							nx.ctrl.slave_addr = pwdata_in[`ATS_CTRL_ADDR_LSB +: 5];
						end
						nx.ctrl.ad_mode = pwdata_in[`ATS_CTRL_AD_BIT];
						if (pwdata_in[`ATS_CTRL_VAR_LSB +: 2] == 2'h3) begin
							nx.ctrl.variant = standard_variant;
						end else begin
							nx.ctrl.variant = ats_variant_t'(pwdata_in[`ATS_CTRL_VAR_LSB +: 2]);
						end
					end else begin
						nx.prdata[`ATS_CTRL_ADDR_LSB +: 5] = st.ctrl.slave_addr;
						nx.prdata[`ATS_CTRL_AD_BIT] = st.ctrl.ad_mode;
						nx.prdata[`ATS_CTRL_VAR_LSB +: 2] = st.ctrl.variant;
					end
				end
				`ATS_OFF_STATUS: begin
					if (!pwrite_in) begin
						nx.prdata[6:0] = st.fsm;
						nx.prdata[7] = st.release_q;
						nx.prdata[11:8] = st.param;
						nx.prdata[12] = st.nv.stored_valid;
						nx.prdata[13] = inhib_act;
						nx.prdata[14] = st.fault;
					end
				end
				`ATS_OFF_IRQ_STAT: begin
					if (pwrite_in) begin
						clr = pwdata_in[4:0];
					end else begin
						nx.prdata[4:0] = st.irq_stat;
					end
				end
				`ATS_OFF_IRQ_MASK: begin
					if (pwrite_in) begin
						nx.irq_mask = pwdata_in[4:0];
					end else begin
						nx.prdata[4:0] = st.irq_mask;
					end
				end
				default: begin
					nx.pslverr = 1'b1;
				end
			endcase
		end

		// pairing sequence
		case (st.fsm)
			ST_BOOT: begin
				nx.nv = nv_in;
				nx.teach_ok = 1'b1;
				if (nv_in.pend_valid) begin
					nx.fsm = ST_ARMED;
				end else if (nv_in.inhibit) begin
					nx.fsm = ST_INHIBIT;
					nx.need_detect = 1'b1;
				end else begin
					nx.fsm = ST_RUN;
				end
			end
			ST_RUN: begin
				if (sn.present && sn.hyst) begin
					if (st.tick && !hyst_long) begin
						nx.tmr = st.tmr + 16'h0001;
					end
				end else begin
					nx.tmr = '0;
				end
				if (matched) begin
					nx.teach_ok = 1'b0;
					nx.need_detect = 1'b0;
				end
				if (sn.present && !paired && st.teach_ok
						&& !(st.ctrl.variant == one_time_pairing_variant
						&& st.nv.stored_valid)) begin
					nx.fsm = ST_TEACH;
					nx.teach_ok = 1'b0;
					nx.nv.pend_code = sn.code;
					ev[`ATS_IRQ_TEACH] = 1'b1;
				end
			end
			ST_TEACH: begin
				if (!sn.present || sn.code != st.nv.pend_code) begin
					nx.fsm = ST_RUN;
				end else if (st.tick) begin
					nx.tmr = st.tmr + 16'h0001;
					if (st.tmr == 16'(`ATS_TEACH_TICKS - 1)) begin
						nx.fsm = ST_PWROFF;
						nx.nv.pend_valid = 1'b1;
						nx.nv_wr = 1'b1;
						ev[`ATS_IRQ_PWROFF] = 1'b1;
					end
				end
			end
			ST_PWROFF: begin
				if (st.tick) begin
					nx.tmr = st.tmr + 16'h0001;
					if (st.tmr == 16'(`ATS_PWROFF_TICKS - 1)) begin
						nx.fsm = ST_FAULT;
						nx.nv.pend_valid = 1'b0;
						nx.nv_wr = 1'b1;
						ev[`ATS_IRQ_ABORT] = 1'b1;
					end
				end
			end
			ST_FAULT: begin
				if (st.tick && st.ph == period - 7'h01) begin
					nx.fcnt = st.fcnt + 3'h1;
					if (st.fcnt == 3'(`ATS_FAULT_FLASHES - 1)) begin
						nx.fsm = ST_RUN;
					end
				end
			end
			ST_ARMED: begin
				if (sn.present && sn.code == st.nv.pend_code) begin
					nx.nv.stored_valid = 1'b1;
					nx.nv.stored_code = st.nv.pend_code;
					nx.nv.pend_valid = 1'b0;
					nx.nv_wr = 1'b1;
					nx.teach_ok = 1'b0;
					ev[`ATS_IRQ_COMMIT] = 1'b1;
					if (st.ctrl.variant == repeatable_pairing_variant) begin
						nx.fsm = ST_INHIBIT;
						nx.nv.inhibit = 1'b1;
					end else begin
						nx.fsm = ST_RUN;
					end
				end
			end
			ST_INHIBIT: begin
				if (matched) begin
					nx.need_detect = 1'b0;
				end
				if (st.tick) begin
					nx.tmr = st.tmr + 16'h0001;
					if (st.tmr == 16'(`ATS_INHIB_TICKS - 1)) begin
						nx.fsm = ST_RUN;
						nx.nv.inhibit = 1'b0;
						nx.nv_wr = 1'b1;
						ev[`ATS_IRQ_INHIB_END] = 1'b1;
					end
				end
			end
			default: begin
				nx.fsm = ST_BOOT;
			end
		endcase
		if (nx.fsm != st.fsm) begin
			nx.tmr = '0;
			nx.ph = '0;
			nx.fcnt = '0;
		end

		// set wins over a write-one clear
		nx.irq_stat = (st.irq_stat & ~clr) | ev;
		nx.irq = |(nx.irq_stat & nx.irq_mask);

		// indicators and outputs
		nx.release_q = (st.fsm == ST_RUN) && paired && !sn.int_err;
		case (st.fsm)
			ST_RUN: begin
				if (sn.int_err) begin
					nx.yel = 1'b1;
				end else if (hyst_long) begin
					nx.yel = blink_on;
				end else begin
					nx.yel = paired;
				end
			end
			ST_TEACH: nx.yel = (st.ph < 7'(`ATS_TEACH_PER / 2));
			ST_PWROFF: nx.yel = (st.ph < 7'(`ATS_REQ_ON_TICKS));
			ST_FAULT: nx.yel = (st.ph < 7'(`ATS_BLINK_PER / 2));
			default: nx.yel = 1'b0;
		endcase
		if (st.ctrl.slave_addr == 5'h00) begin
			nx.duo_red = 1'b1;
			nx.duo_grn = 1'b0;
		end else if (inhib_act || st.fault) begin
			nx.duo_red = blink_on;
			nx.duo_grn = !blink_on;
		end else begin
			nx.duo_red = 1'b0;
			nx.duo_grn = 1'b1;
		end
		if (st.ctrl.ad_mode) begin
			nx.param = sn.present ? sn.num : 4'h0;
		end else begin
			nx.param = {sn.int_err, inhib_act, sn.present && sn.hyst, sn.present};
		end
		nx.fault = sn.int_err || inhib_act || (sn.present && sn.hyst);
	end

	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			st <= '0;
			st.fsm <= ST_BOOT;
		end else begin
			st <= nx;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	assign prdata_out = st.prdata;
	assign pready_out = st.pready;
	assign pslverr_out = st.pslverr;
	assign nv_wr_out = st.nv_wr;
	assign nv_out = st.nv;
	assign release_out = st.release_q;
	assign yel_led_out = st.yel;
	assign duo_red_out = st.duo_red;
	assign duo_grn_out = st.duo_grn;
	assign param_out = st.param;
	assign fault_flag_out = st.fault;
	assign irq_out = st.irq;

	//////////////////////////////////////////////////////////////////////////
	property p_rel_inhibit;
		@(posedge ref_clk_in) disable iff (!resetn_in)
		(st.fsm == ST_INHIBIT) |=> !release_out;
	endproperty
	a_rel_inhibit: assert property (p_rel_inhibit) else $error("release during inhibit");

	property p_yel_steady;
		@(posedge ref_clk_in) disable iff (!resetn_in)
		(st.fsm == ST_RUN && paired && !hyst_long && !sn.int_err) |=> yel_led_out;
	endproperty
	a_yel_steady: assert property (p_yel_steady) else $error("yellow not steady");

	property p_ad_zero;
		@(posedge ref_clk_in) disable iff (!resetn_in)
		(st.ctrl.ad_mode && !sn.present) |=> (param_out == 4'h0);
	endproperty
	a_ad_zero: assert property (p_ad_zero) else $error("parameter not zero");

	property p_ad_num;
		@(posedge ref_clk_in) disable iff (!resetn_in)
		(st.ctrl.ad_mode && sn.present) |=> (param_out == $past(sn.num));
	endproperty
	a_ad_num: assert property (p_ad_num) else $error("actuator number wrong");

	property p_teach_end;
		@(posedge ref_clk_in) disable iff (!resetn_in)
		(st.fsm == ST_TEACH && st.tick && sn.present && sn.code == st.nv.pend_code
			&& st.tmr == 16'(`ATS_TEACH_TICKS - 1))
			|=> (st.fsm == ST_PWROFF) && nv_wr_out && nv_out.pend_valid;
	endproperty
	a_teach_end: assert property (p_teach_end) else $error("no power-off request");

	property p_pwroff_abort;
		@(posedge ref_clk_in) disable iff (!resetn_in)
		(st.fsm == ST_PWROFF && st.tick && st.tmr == 16'(`ATS_PWROFF_TICKS - 1))
			|=> (st.fsm == ST_FAULT) ##1 (st.fsm == ST_FAULT);
	endproperty
	a_pwroff_abort: assert property (p_pwroff_abort) else $error("pairing not aborted");

	property p_once_refuse;
		@(posedge ref_clk_in) disable iff (!resetn_in)
		(st.fsm == ST_RUN && st.ctrl.variant == one_time_pairing_variant
			&& st.nv.stored_valid) |=> (st.fsm != ST_TEACH);
	endproperty
	a_once_refuse: assert property (p_once_refuse) else $error("one-time re-paired");

	property p_std_no_teach;
		@(posedge ref_clk_in) disable iff (!resetn_in)
		(st.fsm == ST_RUN && st.ctrl.variant == standard_variant && sn.present
			&& !sn.int_err) |=> release_out && (st.fsm != ST_TEACH);
	endproperty
	a_std_no_teach: assert property (p_std_no_teach) else $error("standard not released");

	property p_duo_inhibit;
		@(posedge ref_clk_in) disable iff (!resetn_in)
		(st.fsm == ST_INHIBIT && st.ctrl.slave_addr != 5'h00) |=> (duo_red_out != duo_grn_out);
	endproperty
	a_duo_inhibit: assert property (p_duo_inhibit) else $error("duo led not alternating");

	property p_fault_flag;
		@(posedge ref_clk_in) disable iff (!resetn_in)
		(!st.ctrl.ad_mode && !$past(st.ctrl.ad_mode)) |-> (fault_flag_out == |param_out[3:1]);
	endproperty
	a_fault_flag: assert property (p_fault_flag) else $error("fault flag mismatch");

endmodule // ats_sequencer

`default_nettype wire

// ---- src/ats_consts.svh ----
// timing, offset and field constants of the actuator teach-in sequencer
`ifndef ATS_CONSTS_SVH
`define ATS_CONSTS_SVH

// system clock and the 10 ms timer tick
`define ATS_CLK_NS 5
`define ATS_TICK_MS 10
`define ATS_TICK_NS (`ATS_TICK_MS * 1000000)
`define ATS_TICK_CYC (`ATS_TICK_NS / `ATS_CLK_NS)
`define ATS_PRE_W 21

// intervals, in their own unit, then in ticks
`define ATS_TEACH_S 10
`define ATS_TEACH_TICKS (`ATS_TEACH_S * 1000 / `ATS_TICK_MS)
`define ATS_PWROFF_MIN 5
`define ATS_PWROFF_TICKS (`ATS_PWROFF_MIN * 60000 / `ATS_TICK_MS)
`define ATS_INHIB_MIN 10
`define ATS_INHIB_TICKS (`ATS_INHIB_MIN * 60000 / `ATS_TICK_MS)
`define ATS_HYST_DLY_MS 500
`define ATS_HYST_DLY_TICKS (`ATS_HYST_DLY_MS / `ATS_TICK_MS)
`define ATS_TMR_W 16

// flash rates, in Hz, then periods in ticks
`define ATS_TEACH_HZ 1
`define ATS_TEACH_PER (1000 / `ATS_TICK_MS / `ATS_TEACH_HZ)
`define ATS_REQ_HZ 3
`define ATS_REQ_PER (1000 / `ATS_TICK_MS / `ATS_REQ_HZ)
`define ATS_REQ_ON_MS 50
`define ATS_REQ_ON_TICKS (`ATS_REQ_ON_MS / `ATS_TICK_MS)
`define ATS_BLINK_HZ 2
`define ATS_BLINK_PER (1000 / `ATS_TICK_MS / `ATS_BLINK_HZ)
`define ATS_FAULT_FLASHES 5
`define ATS_PH_W 7

// register byte offsets
`define ATS_OFF_CTRL 8'h00
`define ATS_OFF_STATUS 8'h04
`define ATS_OFF_IRQ_STAT 8'h08
`define ATS_OFF_IRQ_MASK 8'h0C

// control register fields and slave address limits
`define ATS_CTRL_VAR_LSB 0
`define ATS_CTRL_AD_BIT 2
`define ATS_CTRL_ADDR_LSB 8
`define ATS_CTRL_ADDR_MIN 5'h01
`define ATS_CTRL_ADDR_MAX 5'h1F

// interrupt event bits
`define ATS_IRQ_W 5
`define ATS_IRQ_TEACH 0
`define ATS_IRQ_PWROFF 1
`define ATS_IRQ_ABORT 2
`define ATS_IRQ_COMMIT 3
`define ATS_IRQ_INHIB_END 4

`endif

// ---- src/ats_pkg.sv ----
// types of the actuator teach-in sequencer
package ats_pkg;

	typedef enum logic [6:0] {
		ST_BOOT = 7'h01,
		ST_RUN = 7'h02,
		ST_TEACH = 7'h04,
		ST_PWROFF = 7'h08,
		ST_FAULT = 7'h10,
		ST_ARMED = 7'h20,
		ST_INHIBIT = 7'h40
	} ats_fsm_t;

	typedef enum logic [1:0] {
		standard_variant = 2'h0,
		one_time_pairing_variant = 2'h1,
		repeatable_pairing_variant = 2'h2
	} ats_variant_t;

	// actuator sensing front end
	typedef struct packed {
		logic present;
		logic hyst;
		logic int_err;
		logic [7:0] code;
		logic [3:0] num;
	} ats_sense_t;

	// non-volatile pairing record
	typedef struct packed {
		logic stored_valid;
		logic [7:0] stored_code;
		logic pend_valid;
		logic [7:0] pend_code;
		logic inhibit;
	} ats_nv_t;

	typedef struct packed {
		logic [4:0] slave_addr;
		logic ad_mode;
		ats_variant_t variant;
	} ats_ctrl_t;

	typedef struct packed {
		ats_fsm_t fsm;
		ats_ctrl_t ctrl;
		ats_nv_t nv;
		logic teach_ok;
		logic need_detect;
		logic [20:0] pre;
		logic tick;
		logic [15:0] tmr;
		logic [6:0] ph;
		logic [6:0] blink;
		logic [2:0] fcnt;
		logic [4:0] irq_stat;
		logic [4:0] irq_mask;
		logic irq;
		logic release_q;
		logic yel;
		logic duo_red;
		logic duo_grn;
		logic [3:0] param;
		logic fault;
		logic nv_wr;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} ats_state_t;

endpackage

// ---- src/ats_pin_sync.sv ----
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module ats_pin_sync #(
	parameter int W = 1
) (
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] pin_out
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} ats_sync_t;

	ats_sync_t st;
	ats_sync_t nx;

	// a bit moves only once the second and third stages agree
	always_comb begin
		nx = st;
		nx.s1 = pin_in;
		nx.s2 = st.s1;
		nx.s3 = st.s2;
		nx.q = (st.s3 & ~(st.s2 ^ st.s3)) | (st.q & (st.s2 ^ st.s3));
	end

	always_ff @(posedge ref_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			st <= '0;
		end else begin
			st <= nx;
		end
	end

	assign pin_out = st.q;

endmodule // ats_pin_sync

`default_nettype wire

// ---- testbench/ats_nv_model.sv ----
// far-side model: non-volatile pairing store and cyclic release poll
`timescale 1ns/1ps
`default_nettype none

module ats_nv_model import ats_pkg::*; (
	input wire logic ref_clk_in,
	input wire logic nv_wr_in,
	input wire ats_nv_t nv_data_in,
	input wire logic release_in,
	output ats_nv_t nv_out,
	output logic release_seen_out
);
	logic [3:0] poll_cnt;
	logic prev_rel;

	initial begin
		nv_out = '0;
		poll_cnt = '0;
		prev_rel = 1'b0;
		release_seen_out = 1'b0;
	end

	// the record survives device reset, like a real store
	always @(posedge ref_clk_in) begin
		if (nv_wr_in)
			nv_out <= nv_data_in;
		poll_cnt <= poll_cnt + 4'h1;
		if (poll_cnt == 4'h0) begin
			prev_rel <= release_in;
			// dependent channels: release only once two polls agree
			release_seen_out <= release_in && prev_rel;
		end
	end
endmodule // ats_nv_model
`default_nettype wire

// ---- testbench/tb_actuator_teach_in_sequencer.sv ----
// self-checking bench of the pairing sequencer
`timescale 1ns/1ps
`default_nettype none

module tb_actuator_teach_in_sequencer import ats_pkg::*;;
	logic ref_clk_in, resetn_in, psel, penable, pwrite, pready, pslverr, nv_wr;
	logic rel, yel, red, grn, fault, irq, polled, yel_q, red_q, er;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] param;
	ats_sense_t sense;
	ats_nv_t nv_q, nv_d;
	int err_count, check_count, cyc, yel_rise, red_rise, t0;

	ats_sequencer #(.TICK_CYCLES(1)) u_ats_sequencer (.ref_clk_in(ref_clk_in),
		.resetn_in(resetn_in), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
		.paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
		.pslverr_out(pslverr), .sense_in(sense), .nv_in(nv_q), .nv_wr_out(nv_wr),
		.nv_out(nv_d), .release_out(rel), .yel_led_out(yel), .duo_red_out(red),
		.duo_grn_out(grn), .param_out(param), .fault_flag_out(fault), .irq_out(irq));
	ats_nv_model u_ats_nv_model (.ref_clk_in(ref_clk_in), .nv_wr_in(nv_wr),
		.nv_data_in(nv_d), .release_in(rel), .nv_out(nv_q), .release_seen_out(polled));

	initial begin
		ref_clk_in = 1'b0;
		forever #2.5 ref_clk_in = ~ref_clk_in;
	end

	//////////////////////////////////////////////////////////////////////////////
	// edge counters and hang guard, on the falling edge so tasks never race them
	always @(negedge ref_clk_in) begin
		cyc++;
		yel_q <= yel;
		red_q <= red;
		if (yel && !yel_q)
			yel_rise++;
		if (red && !red_q)
			red_rise++;
		if (cyc > 100000) begin
			err_count++;
			test_done();
		end
	end

	task test_done;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_in);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk_in);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk_in);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task wait_st(input logic [6:0] s, input int lim);
		int t;
		t = cyc;
		do
			apb(1'b0, 8'h04, 32'h0);
		while (rd[6:0] !== s && cyc - t < lim);
		chk(rd[6:0], s);
	endtask

	task act(input logic p, input logic h, input logic [7:0] c, input logic [3:0] n);
		@(posedge ref_clk_in);
		sense <= '{present: p, hyst: h, int_err: 1'b0, code: c, num: n};
		repeat (8) @(posedge ref_clk_in);
	endtask

	// power cycle, then restore control
	task pwr(input logic [31:0] ctrl);
		@(posedge ref_clk_in);
		resetn_in <= 1'b0;
		repeat (10) @(posedge ref_clk_in);
		resetn_in <= 1'b1;
		repeat (3) @(posedge ref_clk_in);
		apb(1'b1, 8'h00, ctrl);
	endtask

	//////////////////////////////////////////////////////////////////////////////
	// scenarios
	task t_regs;
		chk(red, 1'b1);
		apb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, 8'h00, 32'h1F00);
		apb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h1F00);
		apb(1'b1, 8'h00, 32'h0);
		apb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h1F00);
		apb(1'b1, 8'h00, 32'h0500);
		apb(1'b0, 8'h10, 32'h0);
		chk({31'h0, er}, 32'h1);
		chk(rd, 32'h0);
		chk({red, grn}, 2'b01);
	endtask

	task t_std;
		act(1'b1, 1'b0, 8'h5A, 4'h0);
		chk({rel, yel, param}, 32'h31);
		act(1'b1, 1'b1, 8'h5A, 4'h0);
		repeat (70) @(posedge ref_clk_in);
		yel_rise = 0;
		repeat (100) @(posedge ref_clk_in);
		chk(yel_rise, 2);
		chk({fault, param}, 32'h13);
		act(1'b0, 1'b0, 8'h5A, 4'h0);
		chk(param, 4'h0);
	endtask

	task t_ad;
		apb(1'b1, 8'h00, 32'h0504);
		act(1'b1, 1'b0, 8'h5A, 4'h7);
		chk(param, 4'h7);
		act(1'b1, 1'b0, 8'h5A, 4'hF);
		chk(param, 4'hF);
		act(1'b0, 1'b0, 8'h5A, 4'hF);
		chk(param, 4'h0);
	endtask

	task t_onetime;
		pwr(32'h0501);
		apb(1'b1, 8'h0C, 32'h1F);
		act(1'b1, 1'b0, 8'h5A, 4'h0);
		wait_st(7'h04, 40);
		chk(irq, 1'b1);
		apb(1'b1, 8'h08, 32'h1);
		apb(1'b0, 8'h08, 32'h0);
		chk({irq, rd[0]}, 2'b00);
		yel_rise = 0;
		repeat (200) @(posedge ref_clk_in);
		chk(yel_rise, 2);
		wait_st(7'h08, 1100);
		chk(nv_q.pend_valid, 1'b1);
		yel_rise = 0;
		repeat (198) @(posedge ref_clk_in);
		chk(yel_rise, 6);
		act(1'b0, 1'b0, 8'h5A, 4'h0);
		pwr(32'h0501);
		wait_st(7'h20, 20);
		chk(rel, 1'b0);
		act(1'b1, 1'b0, 8'h5A, 4'h0);
		wait_st(7'h02, 40);
		chk({nv_q.stored_valid, nv_q.stored_code, rel}, 32'h2B5);
	endtask

	task t_refuse;
		act(1'b0, 1'b0, 8'h3C, 4'h0);
		pwr(32'h0501);
		act(1'b1, 1'b0, 8'h3C, 4'h0);
		repeat (20) @(posedge ref_clk_in);
		apb(1'b0, 8'h04, 32'h0);
		chk({rd[6:0], rel}, {7'h02, 1'b0});
	endtask

	task t_abort;
		act(1'b0, 1'b0, 8'h3C, 4'h0);
		pwr(32'h0502);
		act(1'b1, 1'b0, 8'h3C, 4'h0);
		wait_st(7'h04, 40);
		wait_st(7'h08, 1100);
		wait_st(7'h10, 30100);
		yel_rise = int'(yel);
		wait_st(7'h02, 400);
		chk(yel_rise, 5);
		chk(nv_q.pend_valid, 1'b0);
	endtask

	task t_inhibit;
		act(1'b0, 1'b0, 8'h3C, 4'h0);
		pwr(32'h0502);
		act(1'b1, 1'b0, 8'h3C, 4'h0);
		wait_st(7'h04, 40);
		wait_st(7'h08, 1100);
		act(1'b0, 1'b0, 8'h3C, 4'h0);
		pwr(32'h0502);
		wait_st(7'h20, 20);
		act(1'b1, 1'b0, 8'h3C, 4'h0);
		wait_st(7'h40, 40);
		chk({nv_q.stored_code, nv_q.inhibit, rel}, 32'hF2);
		red_rise = 0;
		repeat (100) @(posedge ref_clk_in);
		chk(red_rise, 2);
		pwr(32'h0502);
		t0 = cyc;
		wait_st(7'h40, 20);
		wait_st(7'h02, 61000);
		chk(cyc - t0 >= 59980 && cyc - t0 <= 60020, 1);
		chk({rel, nv_q.inhibit}, 2'b10);
		repeat (40) @(posedge ref_clk_in);
		chk(polled, 1'b1);
	endtask

	initial begin
		err_count = 0;
		check_count = 0;
		cyc = 0;
		yel_rise = 0;
		red_rise = 0;
		resetn_in = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		sense = '0;
		repeat (10) @(posedge ref_clk_in);
		resetn_in <= 1'b1;
		repeat (3) @(posedge ref_clk_in);
		t_regs();
		t_std();
		t_ad();
		t_onetime();
		t_refuse();
		t_abort();
		t_inhibit();
		test_done();
	end
endmodule // tb_actuator_teach_in_sequencer
`default_nettype wire
